// *** shared/icm_pkg.sv ***
// package of constants, types and states for the channel mux control
package icm_pkg;
	// general call and reset code bytes in eight bits; id address in seven-bit form
	localparam logic [7:0] GENERAL_CALL_BYTE = 8'h00;
	localparam logic [7:0] SOFT_RESET_CODE   = 8'h06;
	localparam logic [6:0] ID_ADDR_7BIT      = 7'h7C;
	// base codes of the two address groups, seven-bit form
	localparam logic [6:0] BASE_GROUP_E      = 7'h70;
	localparam logic [6:0] BASE_GROUP_B      = 7'h58;
	// channel select field positions and reset value
	localparam int         CH_ENABLE_POS     = 2;
	localparam int         CH_INDEX_HIGH_POS = 1;
	localparam int         CH_INDEX_LOW_POS  = 0;
	localparam logic [7:0] CH_SELECT_RESET   = 8'h04;
	// identification word fields; values are arbitrary
	localparam logic [11:0] ID_MANUFACTURER  = 12'hA5C;
	localparam logic [8:0]  ID_PART          = 9'h123;
	localparam logic [2:0]  ID_REVISION      = 3'h1;
	localparam int          ID_BYTES         = 3;
	// minimum reset pin low time in ns and derived cycles at 100 MHz
	localparam int RESET_LOW_NS  = 100;
	localparam int CLK_PERIOD_NS = 10;
	localparam int RESET_LOW_CYC =
		(RESET_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// address pin sense code
	typedef enum logic [1:0] {
		ICM_PIN_LOW  = 2'h0,
		ICM_PIN_HIGH = 2'h1,
		ICM_PIN_SCL  = 2'h2,
		ICM_PIN_SDA  = 2'h3
	} icm_pin_e;
	// bus condition events from the front end
	typedef struct packed {
		logic start;
		logic stop;
		logic scl_rise;
		logic scl_fall;
		logic sda;
	} icm_bus_ev_s;
	// slave byte engine states, gray along the write path
	typedef enum logic [2:0] {
		ICM_IDLE  = 3'b000,
		ICM_ADDR  = 3'b001,
		ICM_ACK   = 3'b011,
		ICM_WRITE = 3'b010,
		ICM_READ  = 3'b110,
		ICM_RACK  = 3'b111
	} icm_state_e;
endpackage

// *** src/icm_bus_sense.sv ***
// synchronisers and start, stop and edge detection on the upstream bus
`timescale 1ns/100ps
module icm_bus_sense (
	// clock and reset
	input  wire logic                sys_clk,
	input  wire logic                rst,
	// upstream pins
	input  wire logic                scl_in,
	input  wire logic                sda_in,
	// synchronised levels and events
	output icm_pkg::icm_bus_ev_s     bus_ev,
	output logic                     scl_sync
);
	logic [1:0] scl_ff; // two-stage synchroniser for clock
	logic [1:0] sda_ff; // two-stage synchroniser for data
	logic       scl_d;  // delayed synced clock
	logic       sda_d;  // delayed synced data

	// synchronise both lines, then keep a delayed copy for edges
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			scl_ff <= 2'h3;
			sda_ff <= 2'h3;
			scl_d  <= 1'b1;
			sda_d  <= 1'b1;
		end else begin
			scl_ff <= {scl_ff[0], scl_in};
			sda_ff <= {sda_ff[0], sda_in};
			scl_d  <= scl_ff[1];
			sda_d  <= sda_ff[1];
		end
	end

	// events derived from second stage and its delayed copy only
	always_comb begin
		bus_ev.start    = scl_ff[1] & scl_d & sda_d & ~sda_ff[1];
		bus_ev.stop     = scl_ff[1] & scl_d & ~sda_d & sda_ff[1];
		bus_ev.scl_rise = scl_ff[1] & ~scl_d;
		bus_ev.scl_fall = ~scl_ff[1] & scl_d;
		bus_ev.sda      = sda_ff[1];
		scl_sync        = scl_ff[1];
	end
endmodule

// *** src/icm_addr_decode.sv ***
// slave address decode from the two four-level address inputs
`timescale 1ns/100ps
module icm_addr_decode (
	// clock and reset
	input  wire logic                sys_clk,
	input  wire logic                rst,
	// sensed levels of the two address inputs
	input  icm_pkg::icm_pin_e        address_select_low,
	input  icm_pkg::icm_pin_e        address_select_high,
	// decoded seven-bit own address
	output logic [6:0]               own_addr
);
	// maps a pin code to its two address bits within the group
	function automatic logic [1:0] low_bits(icm_pkg::icm_pin_e p);
		case (p)
			icm_pkg::ICM_PIN_SCL:  low_bits = 2'h0;
			icm_pkg::ICM_PIN_LOW:  low_bits = 2'h1;
			icm_pkg::ICM_PIN_SDA:  low_bits = 2'h2;
			default:               low_bits = 2'h3;
		endcase
	endfunction

	icm_pkg::icm_pin_e lo_s1; // first stage, low address input
	icm_pkg::icm_pin_e lo_s2; // second stage, low address input
	icm_pkg::icm_pin_e hi_s1; // first stage, high address input
	icm_pkg::icm_pin_e hi_s2; // second stage, high address input

	// pins come from outside the clock domain: two stages first
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			lo_s1 <= icm_pkg::ICM_PIN_LOW;
			lo_s2 <= icm_pkg::ICM_PIN_LOW;
			hi_s1 <= icm_pkg::ICM_PIN_LOW;
			hi_s2 <= icm_pkg::ICM_PIN_LOW;
		end else begin
			lo_s1 <= address_select_low;
			lo_s2 <= lo_s1;
			hi_s1 <= address_select_high;
			hi_s2 <= hi_s1;
		end
	end

	// register the decoded address so it is steady for the engine
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			own_addr <= icm_pkg::BASE_GROUP_E;
		end else begin
			case (hi_s2)
				icm_pkg::ICM_PIN_LOW:
					own_addr <= icm_pkg::BASE_GROUP_E |
						{4'h0, 1'b0, low_bits(lo_s2)};
				icm_pkg::ICM_PIN_HIGH:
					own_addr <= icm_pkg::BASE_GROUP_E |
						{4'h0, 1'b1, low_bits(lo_s2)};
				icm_pkg::ICM_PIN_SCL:
					own_addr <= icm_pkg::BASE_GROUP_B |
						{4'h0, 1'b0, low_bits(lo_s2)};
				default:
					own_addr <= icm_pkg::BASE_GROUP_B |
						{4'h0, 1'b1, low_bits(lo_s2)};
			endcase
		end
	end
endmodule

// *** src/icm_channel_mux.sv ***
// i2c slave control of a one-of-four channel multiplexer
// Summary of operation
// - ack general call only with write direction
// - ack only reset code byte after general call
// - no ack for later general call bytes
// - reset at stop; repeated start cancels
// - aborted reset leaves registers unchanged
// - hardwired read-only 24-bit identification word
// - ack id target byte only if ours
// - stop or other access abandons id read
// - id bytes sent most significant first
// - master nack ends id read, engine goes idle
// - wrap to first id byte after third
// - keep last written byte; register readable
// - new channel connects only at stop
// - bit two enables, bits one zero pick
// - at most one channel connected at once
// - reset value enables channel zero only
// - reset pin low resets, disconnects channels
// - two address inputs pick sixteen addresses
`timescale 1ns/100ps
module icm_channel_mux (
	// clock and power-on reset
	input  wire logic              sys_clk,
	input  wire logic              rst,
	// active-low reset pin, asynchronous to sys_clk
	input  wire logic              reset_pin_n,
	// upstream bus
	input  wire logic              scl_in,
	input  wire logic              sda_in,
	output logic                   sda_out,
	output logic                   sda_oe,
	// address inputs, sensed level codes
	input  icm_pkg::icm_pin_e      address_select_low,
	input  icm_pkg::icm_pin_e      address_select_high,
	// downstream pair connect enables, one hot or zero
	output logic [3:0]             downstream_channel_pair,
	// register view
	output logic [7:0]             channel_select
);
	icm_pkg::icm_bus_ev_s ev;          // bus events
	logic                 scl_s;       // synced clock level
	logic [6:0]           own_addr;    // our address
	icm_pkg::icm_state_e  state;       // byte engine state
	logic [7:0]           shift;       // receive shift register
	logic [3:0]           bit_cnt;     // bit counter in byte
	logic                 is_read;     // current access direction
	logic [1:0]           mode;        // 0 own,1 gen call,2 id wr,3 id rd
	logic                 gc_bytes;    // byte after the address acked
	logic                 reset_armed; // reset code acked
	logic                 id_pending;  // id target acked, await restart
	logic [1:0]           id_idx;      // id byte index
	logic [7:0]           tx_byte;     // byte being sent
	logic                 ack_drive;   // pull sda low for ack
	logic                 ack_ok;      // decision for ack slot
	logic                 pending_sel; // new selection awaiting stop
	logic [1:0]           rpin_ff;     // reset pin synchroniser
	logic [3:0]           rpin_cnt;    // low time counter
	logic                 pin_reset;   // qualified reset pin
	logic                 soft_reset;  // software reset pulse
	logic                 any_reset;   // combined logic reset
	logic [23:0]          id_word;     // identification word

	// hardwired identification word, read only
	assign id_word = {icm_pkg::ID_MANUFACTURER, icm_pkg::ID_PART,
		icm_pkg::ID_REVISION};

	// reset of the logic from power-on, pin or software command
	assign any_reset = rst | pin_reset | soft_reset;

	// bus front end
	icm_bus_sense u_sense (
		.sys_clk  (sys_clk),
		.rst      (rst),
		.scl_in   (scl_in),
		.sda_in   (sda_in),
		.bus_ev   (ev),
		.scl_sync (scl_s)
	);

	// address decode
	icm_addr_decode u_addr (
		.sys_clk             (sys_clk),
		.rst                 (rst),
		.address_select_low  (address_select_low),
		.address_select_high (address_select_high),
		.own_addr            (own_addr)
	);

	// picks the id byte for an index, most significant first
	function automatic logic [7:0] id_byte(logic [1:0] i,
		logic [23:0] w);
		case (i)
			2'h0:    id_byte = w[23:16];
			2'h1:    id_byte = w[15:8];
			default: id_byte = w[7:0];
		endcase
	endfunction

	// synchronise reset pin and qualify its minimum low time
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			rpin_ff   <= 2'h3;
			rpin_cnt  <= 4'h0;
			pin_reset <= 1'b0;
		end else begin
			rpin_ff <= {rpin_ff[0], reset_pin_n};
			if (rpin_ff[1]) begin
				rpin_cnt  <= 4'h0;
				pin_reset <= 1'b0;
			end else if (rpin_cnt == 4'(icm_pkg::RESET_LOW_CYC - 1)) begin
				pin_reset <= 1'b1;
			end else begin
				rpin_cnt <= rpin_cnt + 4'h1;
			end
		end
	end

	// decision for the ack slot after a received byte
	always_comb begin
		ack_ok = 1'b0;
		if (state == icm_pkg::ICM_ADDR) begin
			if (shift[7:1] == own_addr) begin
				ack_ok = 1'b1;
			end else if (shift == icm_pkg::GENERAL_CALL_BYTE) begin
				ack_ok = 1'b1;
			end else if (shift[7:1] == icm_pkg::ID_ADDR_7BIT) begin
				// write opens id; read only if target was ours
				ack_ok = ~shift[0] | id_pending;
			end
		end else if (state == icm_pkg::ICM_WRITE) begin
			case (mode)
				2'h0:    ack_ok = 1'b1;
				2'h1:    ack_ok = ~gc_bytes &
					(shift == icm_pkg::SOFT_RESET_CODE);
				2'h2:    ack_ok = ~gc_bytes &
					(shift[7:1] == own_addr);
				default: ack_ok = 1'b0;
			endcase
		end
	end

	// byte engine: receives, acks, and sends id or register bytes
	always_ff @(posedge sys_clk) begin
		if (any_reset) begin
			state       <= icm_pkg::ICM_IDLE;
			shift       <= 8'h00;
			bit_cnt     <= 4'h0;
			is_read     <= 1'b0;
			mode        <= 2'h0;
			gc_bytes    <= 1'b0;
			reset_armed <= 1'b0;
			id_pending  <= 1'b0;
			id_idx      <= 2'h0;
			tx_byte     <= 8'h00;
			ack_drive   <= 1'b0;
		end else if (ev.start) begin
			// repeated start cancels an armed reset
			state       <= icm_pkg::ICM_ADDR;
			bit_cnt     <= 4'h0;
			reset_armed <= 1'b0;
			ack_drive   <= 1'b0;
			gc_bytes    <= 1'b0;
		end else if (ev.stop) begin
			// stop abandons any pending id read
			state      <= icm_pkg::ICM_IDLE;
			id_pending <= 1'b0;
			ack_drive  <= 1'b0;
		end else begin
			case (state)
				icm_pkg::ICM_IDLE: begin
					ack_drive <= 1'b0;
				end
				icm_pkg::ICM_ADDR, icm_pkg::ICM_WRITE: begin
					if (ev.scl_rise && bit_cnt < 4'h8) begin
						shift   <= {shift[6:0], ev.sda};
						bit_cnt <= bit_cnt + 4'h1;
					end else if (ev.scl_fall && bit_cnt == 4'h8) begin
						bit_cnt <= 4'h0;
						if (ack_ok) begin
							ack_drive <= 1'b1;
							if (state == icm_pkg::ICM_ADDR) begin
								is_read <= shift[0];
								if (shift[7:1] == icm_pkg::ID_ADDR_7BIT) begin
									mode   <= shift[0] ? 2'h3 : 2'h2;
									id_idx <= 2'h0;
								end else if (shift == 8'h00) begin
									mode <= 2'h1;
								end else begin
									mode <= 2'h0;
								end
								// access to anyone else drops id pending
								if (shift[7:1] != icm_pkg::ID_ADDR_7BIT)
									id_pending <= 1'b0;
							end else begin
								if (mode == 2'h1)
									reset_armed <= 1'b1;
								if (mode == 2'h2)
									id_pending <= 1'b1;
								gc_bytes <= 1'b1;
							end
							state <= icm_pkg::ICM_ACK;
						end else begin
							// nack: armed reset dropped, id pending dropped on address byte, engine goes idle
							state       <= icm_pkg::ICM_IDLE;
							reset_armed <= 1'b0;
							if (state == icm_pkg::ICM_ADDR)
								id_pending <= 1'b0;
						end
					end
				end
				icm_pkg::ICM_ACK: begin
					if (ev.scl_fall) begin
						if (is_read) begin
							state     <= icm_pkg::ICM_READ;
							ack_drive <= 1'b0;
							tx_byte   <= (mode == 2'h3) ?
								id_byte(id_idx, id_word) : channel_select;
						end else begin
							state     <= icm_pkg::ICM_WRITE;
							ack_drive <= 1'b0;
						end
					end
				end
				icm_pkg::ICM_READ: begin
					if (ev.scl_fall) begin
						if (bit_cnt == 4'h7) begin
							bit_cnt <= 4'h0;
							state   <= icm_pkg::ICM_RACK;
						end else begin
							bit_cnt <= bit_cnt + 4'h1;
							tx_byte <= {tx_byte[6:0], 1'b0};
						end
					end
				end
				icm_pkg::ICM_RACK: begin
					if (ev.scl_rise) begin
						if (ev.sda) begin
							state <= icm_pkg::ICM_IDLE;
						end else begin
							state   <= icm_pkg::ICM_ACK;
							// wrap after the third id byte
							id_idx  <= (id_idx == 2'(icm_pkg::ID_BYTES - 1)) ?
								2'h0 : id_idx + 2'h1;
						end
					end
				end
				default: state <= icm_pkg::ICM_IDLE;
			endcase
		end
	end

	// software reset pulse when stop follows an armed reset
	always_ff @(posedge sys_clk) begin
		if (rst | pin_reset)
			soft_reset <= 1'b0;
		else
			soft_reset <= ev.stop & reset_armed & ~soft_reset;
	end

	// control register keeps the last byte written
	always_ff @(posedge sys_clk) begin
		if (any_reset) begin
			channel_select <= icm_pkg::CH_SELECT_RESET;
			pending_sel    <= 1'b1;
		end else if (state == icm_pkg::ICM_WRITE && mode == 2'h0 &&
			ev.scl_fall && bit_cnt == 4'h8) begin
			channel_select <= shift;
			pending_sel    <= 1'b1;
		end else if (ev.stop) begin
			pending_sel <= 1'b0;
		end
	end

	// channel connect updates only on a stop; pin reset disconnects
	always_ff @(posedge sys_clk) begin
		if (rst | pin_reset) begin
			downstream_channel_pair <= 4'h0;
		end else if (ev.stop && pending_sel) begin
			if (channel_select[icm_pkg::CH_ENABLE_POS])
				downstream_channel_pair <= 4'h1 << {
					channel_select[icm_pkg::CH_INDEX_HIGH_POS],
					channel_select[icm_pkg::CH_INDEX_LOW_POS]};
			else
				downstream_channel_pair <= 4'h0;
		end
	end

	// sda drive: ack slot low, or shifted data bit when zero
	always_ff @(posedge sys_clk) begin
		if (any_reset) begin
			sda_out <= 1'b0;
			sda_oe  <= 1'b0;
		end else begin
			sda_out <= 1'b0;
			sda_oe  <= ack_drive |
				((state == icm_pkg::ICM_READ) & ~tx_byte[7]);
		end
	end
endmodule

// *** test/icm_channel_mux_sva.sv ***
// port checks for the channel mux control
`timescale 1ns/100ps
module icm_channel_mux_sva (
	// clock and resets
	input wire logic       sys_clk,
	input wire logic       rst,
	input wire logic       reset_pin_n,
	// upstream bus
	input wire logic       scl_in,
	input wire logic       sda_in,
	input wire logic       sda_oe,
	// outputs under watch
	input wire logic [3:0] downstream_channel_pair,
	input wire logic [7:0] channel_select
);
	logic       in_frame; // between start and stop on the pins
	logic       sda_prev; // data level one cycle back
	logic [3:0] low_cnt;  // reset pin low cycles, saturating
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	// frame tracking from raw pin conditions
	always_ff @(posedge sys_clk) begin
		sda_prev <= sda_in;
		if (rst)
			in_frame <= 1'b0;
		else if (scl_in && sda_prev && !sda_in)
			in_frame <= 1'b1;
		else if (scl_in && !sda_prev && sda_in)
			in_frame <= 1'b0;
	end
	// count how long the reset pin has been low
	always_ff @(posedge sys_clk) begin
		if (reset_pin_n)
			low_cnt <= 4'h0;
		else if (low_cnt != 4'hF)
			low_cnt <= low_cnt + 4'h1;
	end
	// device pull seen as clock goes high
	sequence s_pull_high;
		$rose(scl_in) && sda_oe;
	endsequence
	property p_one_chan;
		$onehot0(downstream_channel_pair);
	endproperty
	property p_rst_vals;
		$fell(rst) |-> downstream_channel_pair == 4'h0
			&& channel_select == 8'h04 && !sda_oe;
	endproperty
	property p_pin_rst;
		low_cnt == 4'hF |-> downstream_channel_pair == 4'h0
			&& channel_select == 8'h04;
	endproperty
	property p_oe_scl_low;
		$changed(sda_oe) |-> !scl_in;
	endproperty
	property p_oe_hold;
		s_pull_high |-> sda_oe[*5];
	endproperty
	property p_oe_idle;
		!in_frame |-> !sda_oe;
	endproperty
	property p_pair_frame;
		in_frame |=> $stable(downstream_channel_pair);
	endproperty
	property p_sel_frame;
		in_frame && scl_in |=> $stable(channel_select);
	endproperty
	a_one_chan: assert property (p_one_chan)
		else $error("more than one channel connected");
	a_rst_vals: assert property (p_rst_vals)
		else $error("wrong values after reset");
	a_pin_rst: assert property (p_pin_rst)
		else $error("reset pin did not clear state");
	a_oe_scl_low: assert property (p_oe_scl_low)
		else $error("data drive changed with clock high");
	a_oe_hold: assert property (p_oe_hold)
		else $error("data drive dropped in clock high");
	a_oe_idle: assert property (p_oe_idle)
		else $error("data driven outside a frame");
	a_pair_frame: assert property (p_pair_frame)
		else $error("channel changed inside a frame");
	a_sel_frame: assert property (p_sel_frame)
		else $error("register changed in clock high");
endmodule
bind icm_channel_mux icm_channel_mux_sva u_icm_channel_mux_sva (
	.sys_clk(sys_clk), .rst(rst), .reset_pin_n(reset_pin_n),
	.scl_in(scl_in), .sda_in(sda_in), .sda_oe(sda_oe),
	.downstream_channel_pair(downstream_channel_pair),
	.channel_select(channel_select)
);

// *** test/icm_master_model.sv ***
// bus master model driving the upstream clock and data
`timescale 1ns/100ps
module icm_master_model (
	// clock
	input wire logic sys_clk,
	// upstream bus
	output logic     scl_in,
	output logic     sda_in,
	input wire logic sda_oe
);
	logic sda_drv = 1'b1; // master data drive, 1 is released
	initial scl_in = 1'b1;
	// open-drain wire with pull-up
	assign sda_in = sda_drv & ~sda_oe;
	// quarter bit time, keeps each clock phase ten cycles
	task automatic q();
		repeat (5) @(posedge sys_clk);
	endtask
	// start or repeated start, ends with clock low
	task automatic start();
		sda_drv <= 1'b1;
		q();
		scl_in <= 1'b1;
		q();
		sda_drv <= 1'b0;
		q();
		scl_in <= 1'b0;
		q();
	endtask
	// stop from clock low
	task automatic stop();
		sda_drv <= 1'b0;
		q();
		scl_in <= 1'b1;
		q();
		sda_drv <= 1'b1;
		q();
	endtask
	// one bit out, wire sampled mid high phase
	task automatic bit_io(input logic b, output logic r);
		sda_drv <= b;
		q();
		scl_in <= 1'b1;
		q();
		r = sda_in;
		q();
		scl_in <= 1'b0;
		q();
	endtask
	// byte out msb first, acknowledge returned
	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], r);
		bit_io(1'b1, r);
		ack = ~r;
	endtask
	// byte in msb first, then ack or nack
	task automatic rbyte(input logic nack, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, r);
			d[i] = r;
		end
		bit_io(nack, r);
	endtask
endmodule

// *** test/icm_channel_mux_test.sv ***
// self-checking bench for the channel mux control
`timescale 1ns/100ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin \
	bad_count++; $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module icm_channel_mux_test;
	logic              sys_clk = 1'b0;     // system clock
	logic              rst = 1'b1;         // power-on reset
	logic              reset_pin_n = 1'b1; // reset pin
	logic              scl_in, sda_in;     // bus from master model
	logic              sda_out, sda_oe;    // device data drive
	icm_pkg::icm_pin_e pin_lo, pin_hi;     // address inputs
	logic [3:0]        pair;               // connected channel
	logic [7:0]        sel, own8, v, rd;   // register, address, data
	logic [7:0]        tbl [6];            // corner values
	logic [23:0]       idw;                // expected identification
	logic              ack;
	int                bad_count = 0;
	int                checks_done = 0;
	always #5 sys_clk = ~sys_clk;
	icm_channel_mux u_icm_channel_mux (.sys_clk(sys_clk), .rst(rst),
		.reset_pin_n(reset_pin_n), .scl_in(scl_in), .sda_in(sda_in),
		.sda_out(sda_out), .sda_oe(sda_oe), .address_select_low(pin_lo),
		.address_select_high(pin_hi), .downstream_channel_pair(pair),
		.channel_select(sel));
	icm_master_model u_icm_master_model (.sys_clk(sys_clk),
		.scl_in(scl_in), .sda_in(sda_in), .sda_oe(sda_oe));
	// own address byte from the address input codes
	function automatic logic [7:0] addr_of(input logic [1:0] a0, a1);
		return {1'b1, !a1[1], 1'b1, a1[1], a1[0], a0[0], !a0[1], 1'b0};
	endfunction
	// connect enables expected for a register value
	function automatic logic [3:0] pair_of(input logic [7:0] c);
		return c[2] ? 4'h1 << c[1:0] : 4'h0;
	endfunction
	// verdict and end of run
	task automatic results();
		$display("checks_done %0d bad_count %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// one byte out, acknowledge compared
	task automatic wr(input logic [7:0] b, input logic e);
		u_icm_master_model.wbyte(b, ack);
		`CHK("ack", e, ack)
	endtask
	task automatic go();
		u_icm_master_model.start();
	endtask
	task automatic halt();
		u_icm_master_model.stop();
		repeat (10) @(posedge sys_clk);
	endtask
	// two-byte register write, channel follows only at stop
	task automatic put(input logic [7:0] a, b);
		logic [3:0] p;
		p = pair;
		go();
		wr(own8, 1'b1);
		wr(a, 1'b1);
		wr(b, 1'b1);
		`CHK("sel", b, sel)
		`CHK("pair held", p, pair)
		halt();
		`CHK("pair", pair_of(b), pair)
	endtask
	// register read, no stop
	task automatic rreg(input logic [7:0] e);
		go();
		wr(own8 | 8'h01, 1'b1);
		u_icm_master_model.rbyte(1'b1, rd);
		`CHK("read", e, rd)
	endtask
	initial begin
		void'($urandom(99));
		pin_lo = icm_pkg::icm_pin_e'($urandom_range(3));
		pin_hi = icm_pkg::icm_pin_e'($urandom_range(3));
		own8 = addr_of(pin_lo, pin_hi);
		idw = {icm_pkg::ID_MANUFACTURER, icm_pkg::ID_PART,
			icm_pkg::ID_REVISION};
		tbl = '{8'h00, 8'h04, 8'h05, 8'hFE, 8'h07, 8'hFB};
		repeat (6) @(posedge sys_clk);
		rst <= 1'b0;
		repeat (4) @(posedge sys_clk);
		`CHK("sel", 8'h04, sel)
		`CHK("pair", 4'h0, pair)
		`CHK("sda_out", 1'b0, sda_out)
		for (int i = 0; i < 10; i++) begin
			v = (i < 4) ? 8'($urandom) : tbl[i - 4];
			put(8'($urandom), v);
		end
		rreg(v);
		halt();
		// general call with read direction, then a wrong code
		go();
		wr(8'h01, 1'b0);
		halt();
		go();
		wr(8'h00, 1'b1);
		wr(8'h07, 1'b0);
		halt();
		`CHK("sel", v, sel)
		// reset code cancelled by repeated start
		go();
		wr(8'h00, 1'b1);
		wr(8'h06, 1'b1);
		rreg(v);
		halt();
		`CHK("sel", v, sel)
		go();
		wr(8'h00, 1'b1);
		wr(8'h06, 1'b1);
		halt();
		`CHK("sel", 8'h04, sel)
		go();
		wr(8'h00, 1'b1);
		wr(8'h06, 1'b1);
		wr(8'h06, 1'b0);
		halt();
		// identification read with wrap after third byte
		go();
		wr(8'hF8, 1'b1);
		wr(own8 | 8'h01, 1'b1);
		go();
		wr(8'hF9, 1'b1);
		for (int k = 0; k < 4; k++) begin
			u_icm_master_model.rbyte(k == 3, rd);
			`CHK("id", idw[23 - 8 * (k % 3) -: 8], rd)
		end
		halt();
		go();
		wr(8'hF8, 1'b1);
		wr(own8 ^ 8'h02, 1'b0);
		halt();
		go();
		wr(8'hF8, 1'b1);
		wr(own8, 1'b1);
		halt();
		go();
		wr(8'hF9, 1'b0);
		halt();
		// reset pin with a channel connected
		put(8'h00, 8'h06);
		reset_pin_n <= 1'b0;
		repeat (20) @(posedge sys_clk);
		reset_pin_n <= 1'b1;
		repeat (4) @(posedge sys_clk);
		`CHK("pair", 4'h0, pair)
		`CHK("sel", 8'h04, sel)
		results();
	end
	// watchdog against a hung run
	initial begin
		repeat (100000) @(posedge sys_clk);
		bad_count++;
		results();
	end
endmodule
